//--- rtl/eipg_pkg.sv
// Constants, modes and states of the event interrupt pulse generator.
// Assumes a single 250 MHz core clock; status widths are fixed at eight bits.
package eipg_pkg;

    // ************************************************************
    // Status register layout
    // ************************************************************
    localparam int REG_W   = 8;
    localparam int NUM_REG = 7;
    localparam int NUM_GRP = 6;
    localparam int NUM_REQ = 8;

    // Register indices, groups share the first six
    localparam int IDX_SUP  = 0;
    localparam int IDX_TEMP = 1;
    localparam int IDX_BUS  = 2;
    localparam int IDX_HS   = 3;
    localparam int IDX_BD   = 4;
    localparam int IDX_DEV  = 5;
    localparam int IDX_WAKE = 6;

    // Request vector slots beyond the groups
    localparam int REQ_WAKE  = 6;
    localparam int REQ_BRAKE = 7;

    // Bits kept out of the supply and thermal requests, or picked for device and brake
    localparam logic [REG_W-1:0] SUP_EXCL_MASK   = 8'h0F;  // Power-on, undervoltage, short, overvoltage
    localparam logic [REG_W-1:0] THERM_EXCL_MASK = 8'h02;  // Second shutdown level
    localparam logic [REG_W-1:0] DEV_FAIL_MASK   = 8'h03;  // Serial fail and checksum fail
    localparam logic [REG_W-1:0] BRAKE_OV_MASK   = 8'h38;  // Low-side brake overvoltage bits
    localparam logic [REG_W-1:0] ALL_BITS        = 8'hFF;
    localparam logic [REG_W-1:0] NO_BITS         = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 4;
    localparam int PULSE_WIDTH_US = 100;
    localparam int PULSE_GAP_US   = 100;
    localparam int REPEAT_MS      = 5;
    localparam int PULSE_CYCLES   = (PULSE_WIDTH_US * 1000) / CLK_PERIOD_NS;
    localparam int GAP_CYCLES     = (PULSE_GAP_US * 1000) / CLK_PERIOD_NS;
    localparam int REPEAT_CYCLES  = (REPEAT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TMR_W          = 21;

    // ************************************************************
    // Modes and states
    // ************************************************************
    typedef enum logic [2:0] {
        EIPG_MODE_INIT     = 3'h0,
        EIPG_MODE_NORMAL   = 3'h1,
        EIPG_MODE_STOP     = 3'h2,
        EIPG_MODE_SLEEP    = 3'h3,
        EIPG_MODE_RESTART  = 3'h4,
        EIPG_MODE_FAILSAFE = 3'h5
    } eipg_mode_t;

    typedef enum logic [1:0] {
        EIPG_ST_IDLE = 2'h0,
        EIPG_ST_LOW  = 2'h1,
        EIPG_ST_GAP  = 2'h2
    } eipg_state_t;

endpackage

//--- rtl/eipg_status_latch.sv
// One sticky status register with a host-readable snapshot.
// Assumes set events and clear strobes are synchronous one-cycle levels.
`timescale 1ns/1ns
`default_nettype none
module eipg_status_latch #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Hardware events and host clear
    input  wire logic [W-1:0] set_evt,
    input  wire logic         clr,
    // Snapshot update request
    input  wire logic         snap_load,
    // Latched and readable contents
    output logic      [W-1:0] lat_q,
    output logic      [W-1:0] snap_q
);

    logic [W-1:0] lat_next;
    logic [W-1:0] snap_next;

    // Set wins over clear so an event in the clearing cycle survives
    assign lat_next  = (lat_q & ~{W{clr}}) | set_evt;
    // Snapshot refresh wins; a clear empties the visible copy too
    assign snap_next = snap_load ? lat_q : (clr ? '0 : snap_q);

    // Storage
    always_ff @(posedge clk) begin
        if (rst) begin
            lat_q  <= '0;
            snap_q <= '0;
        end else begin
            lat_q  <= lat_next;
            snap_q <= snap_next;
        end
    end

endmodule
`default_nettype wire

//--- rtl/eipg_top.sv
// Event interrupt pulse generator: active-low pulse output to the host.
// Assumes mode, events and configuration come synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module eipg_top #(
    parameter int PULSE_CYC  = eipg_pkg::PULSE_CYCLES,
    parameter int GAP_CYC    = eipg_pkg::GAP_CYCLES,
    parameter int REPEAT_CYC = eipg_pkg::REPEAT_CYCLES
) (
    // Clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    // Device operating mode
    input  wire eipg_pkg::eipg_mode_t       mode,
    // Hardware events per status register
    input  wire logic [eipg_pkg::REG_W-1:0] supply_evt,
    input  wire logic [eipg_pkg::REG_W-1:0] thermal_evt,
    input  wire logic [eipg_pkg::REG_W-1:0] bus_evt,
    input  wire logic [eipg_pkg::REG_W-1:0] high_side_evt,
    input  wire logic [eipg_pkg::REG_W-1:0] drain_source_overvoltage_reg_evt,
    input  wire logic [eipg_pkg::REG_W-1:0] device_evt,
    input  wire logic [eipg_pkg::REG_W-1:0] wake_evt,
    // Host clear strobes per status register
    input  wire logic                       supply_clr,
    input  wire logic                       thermal_clr,
    input  wire logic                       bus_clr,
    input  wire logic                       high_side_clr,
    input  wire logic                       drain_source_overvoltage_reg_clr,
    input  wire logic                       device_clr,
    input  wire logic                       wake_clr,
    // Configuration
    input  wire logic [eipg_pkg::NUM_GRP-1:0] irq_mask,
    input  wire logic [eipg_pkg::REG_W-1:0] wake_src_en,
    input  wire logic                       brake_enable,
    input  wire logic                       periodic_irq_enable,
    // Readable status
    output logic      [eipg_pkg::REG_W-1:0] supply_status_reg,
    output logic      [eipg_pkg::REG_W-1:0] thermal_status_reg,
    output logic      [eipg_pkg::REG_W-1:0] bus_status_reg,
    output logic      [eipg_pkg::REG_W-1:0] high_side_fault_reg,
    output logic      [eipg_pkg::REG_W-1:0] drain_source_overvoltage_reg,
    output logic      [eipg_pkg::REG_W-1:0] device_status_reg,
    output logic      [eipg_pkg::REG_W-1:0] wake_event_reg,
    // Interrupt pin and init strap
    input  wire logic                       intn_in,
    output logic                            intn_out,
    output logic                            intn_oe,
    output logic                            sdm_select
);

    // ************************************************************
    // Status registers
    // ************************************************************
    localparam int RW = eipg_pkg::REG_W;
    localparam int TW = eipg_pkg::TMR_W;

    logic [RW-1:0] evt_a  [eipg_pkg::NUM_REG];
    logic          clr_a  [eipg_pkg::NUM_REG];
    logic [RW-1:0] lat_a  [eipg_pkg::NUM_REG];
    logic [RW-1:0] snap_a [eipg_pkg::NUM_REG];
    logic          start;

    // Gather per-register inputs into arrays
    assign evt_a[eipg_pkg::IDX_SUP]  = supply_evt;
    assign evt_a[eipg_pkg::IDX_TEMP] = thermal_evt;
    assign evt_a[eipg_pkg::IDX_BUS]  = bus_evt;
    assign evt_a[eipg_pkg::IDX_HS]   = high_side_evt;
    assign evt_a[eipg_pkg::IDX_BD]   = drain_source_overvoltage_reg_evt;
    assign evt_a[eipg_pkg::IDX_DEV]  = device_evt;
    assign evt_a[eipg_pkg::IDX_WAKE] = wake_evt;
    assign clr_a[eipg_pkg::IDX_SUP]  = supply_clr;
    assign clr_a[eipg_pkg::IDX_TEMP] = thermal_clr;
    assign clr_a[eipg_pkg::IDX_BUS]  = bus_clr;
    assign clr_a[eipg_pkg::IDX_HS]   = high_side_clr;
    assign clr_a[eipg_pkg::IDX_BD]   = drain_source_overvoltage_reg_clr;
    assign clr_a[eipg_pkg::IDX_DEV]  = device_clr;
    assign clr_a[eipg_pkg::IDX_WAKE] = wake_clr;

    // Sticky registers; snapshot refreshed as the pulse falls
    for (genvar i = 0; i < eipg_pkg::NUM_REG; i++) begin : g_reg
        eipg_status_latch #(
            .W(RW)
        ) eipg_status_latch_inst (
            .clk       (ref_clk),
            .rst       (sys_rst),
            .set_evt   (evt_a[i]),
            .clr       (clr_a[i]),
            .snap_load (start),
            .lat_q     (lat_a[i]),
            .snap_q    (snap_a[i])
        );
    end

    // Readable copies
    assign supply_status_reg            = snap_a[eipg_pkg::IDX_SUP];
    assign thermal_status_reg           = snap_a[eipg_pkg::IDX_TEMP];
    assign bus_status_reg               = snap_a[eipg_pkg::IDX_BUS];
    assign high_side_fault_reg          = snap_a[eipg_pkg::IDX_HS];
    assign drain_source_overvoltage_reg = snap_a[eipg_pkg::IDX_BD];
    assign device_status_reg            = snap_a[eipg_pkg::IDX_DEV];
    assign wake_event_reg               = snap_a[eipg_pkg::IDX_WAKE];

    // ************************************************************
    // Request sources
    // ************************************************************
    logic [eipg_pkg::NUM_REQ-1:0] req_vec;
    logic [eipg_pkg::NUM_REQ-1:0] req_en;
    logic [eipg_pkg::NUM_REQ-1:0] req_prev_reg;
    logic                         high_side_group_req;
    logic                         bridge_group_req;
    logic                         wake_req;
    logic                         brake_req;
    logic                         trig;

    // Group ORs; supply and thermal drop their reset-forcing bits
    assign high_side_group_req = |lat_a[eipg_pkg::IDX_HS];
    assign bridge_group_req    = |lat_a[eipg_pkg::IDX_BD];
    assign req_vec[eipg_pkg::IDX_SUP]  = |(lat_a[eipg_pkg::IDX_SUP] & ~eipg_pkg::SUP_EXCL_MASK);
    assign req_vec[eipg_pkg::IDX_TEMP] = |(lat_a[eipg_pkg::IDX_TEMP] & ~eipg_pkg::THERM_EXCL_MASK);
    assign req_vec[eipg_pkg::IDX_BUS]  = |lat_a[eipg_pkg::IDX_BUS];
    assign req_vec[eipg_pkg::IDX_HS]   = high_side_group_req;
    assign req_vec[eipg_pkg::IDX_BD]   = bridge_group_req;
    assign req_vec[eipg_pkg::IDX_DEV]  = |(lat_a[eipg_pkg::IDX_DEV] & eipg_pkg::DEV_FAIL_MASK);

    // Wake path: only configured sources, brake bits only when braking
    assign wake_req  = |(lat_a[eipg_pkg::IDX_WAKE] & wake_src_en);
    assign brake_req = brake_enable & (|(lat_a[eipg_pkg::IDX_BD] & eipg_pkg::BRAKE_OV_MASK));
    assign req_vec[eipg_pkg::REQ_WAKE]  = wake_req;
    assign req_vec[eipg_pkg::REQ_BRAKE] = brake_req;

    // Mask gates groups only; wake path stays live alongside
    assign req_en = {2'h3, irq_mask};
    // A request edge triggers; a request already high does not retrigger
    assign trig   = |(req_vec & ~req_prev_reg & req_en);

    // Edge memory of the requests
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            req_prev_reg <= '0;
        end else begin
            req_prev_reg <= req_vec;
        end
    end

    // ************************************************************
    // Mode tracking
    // ************************************************************
    eipg_pkg::eipg_mode_t mode_prev_reg;
    logic                 allowed;
    logic                 stop_entry;
    logic                 sdm_select_reg;
    logic                 sdm_select_next;

    // Pulses only in normal and stop; no path here ever drives mode
    assign allowed    = (mode == eipg_pkg::EIPG_MODE_NORMAL) ||
                        (mode == eipg_pkg::EIPG_MODE_STOP);
    assign stop_entry = (mode == eipg_pkg::EIPG_MODE_STOP) &&
                        (mode_prev_reg != eipg_pkg::EIPG_MODE_STOP) &&
                        ((|lat_a[eipg_pkg::IDX_WAKE]) ||
                         (|(lat_a[eipg_pkg::IDX_BD] & eipg_pkg::BRAKE_OV_MASK)));
    // Strap level follows the pin throughout init, then holds
    assign sdm_select_next = (mode == eipg_pkg::EIPG_MODE_INIT) ? intn_in : sdm_select_reg;

    // Previous mode and development-mode strap
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_prev_reg  <= eipg_pkg::EIPG_MODE_INIT;
            sdm_select_reg <= 1'b0;
        end else begin
            mode_prev_reg  <= mode;
            sdm_select_reg <= sdm_select_next;
        end
    end

    assign sdm_select = sdm_select_reg;

    // ************************************************************
    // Periodic repeat timer
    // ************************************************************
    logic          rep_run;
    logic          rep_due;
    logic [TW-1:0] rep_cnt_reg;
    logic [TW-1:0] rep_cnt_next;

    // Runs from each pulse start while serial or checksum fail stays set
    assign rep_run      = allowed && periodic_irq_enable &&
                          req_vec[eipg_pkg::IDX_DEV] && irq_mask[eipg_pkg::IDX_DEV];
    assign rep_due      = rep_run && (rep_cnt_reg == TW'(REPEAT_CYC - 1));
    assign rep_cnt_next = (!rep_run || start) ? '0 : rep_cnt_reg + TW'(1);

    // Repeat counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rep_cnt_reg <= '0;
        end else begin
            rep_cnt_reg <= rep_cnt_next;
        end
    end

    // ************************************************************
    // Pulse sequencer
    // ************************************************************
    eipg_pkg::eipg_state_t state_reg;
    eipg_pkg::eipg_state_t state_next;
    logic [TW-1:0]         tmr_reg;
    logic [TW-1:0]         tmr_next;
    logic                  pending_reg;
    logic                  pending_next;
    logic                  set_req;
    logic                  intn_out_reg;
    logic                  low_done;
    logic                  gap_done;

    assign set_req  = trig || stop_entry || rep_due;
    assign start    = allowed && (state_reg == eipg_pkg::EIPG_ST_IDLE) && (pending_reg || set_req);
    assign low_done = (tmr_reg == TW'(PULSE_CYC - 1));
    assign gap_done = (tmr_reg == TW'(GAP_CYC - 1));
    // Requests during the low phase fold into the running pulse
    assign pending_next = (!allowed || start || (state_reg == eipg_pkg::EIPG_ST_LOW)) ?
                          1'b0 : (pending_reg || set_req);

    // Next state; a mode drop mid-pulse still serves the gap
    always_comb begin
        state_next = state_reg;
        tmr_next   = tmr_reg + TW'(1);
        case (state_reg)
            eipg_pkg::EIPG_ST_IDLE: begin
                tmr_next = '0;
                if (start) begin
                    state_next = eipg_pkg::EIPG_ST_LOW;
                end
            end
            eipg_pkg::EIPG_ST_LOW: begin
                if (low_done || !allowed) begin
                    state_next = eipg_pkg::EIPG_ST_GAP;
                    tmr_next   = '0;
                end
            end
            eipg_pkg::EIPG_ST_GAP: begin
                if (gap_done) begin
                    state_next = eipg_pkg::EIPG_ST_IDLE;
                    tmr_next   = '0;
                end
            end
            default: begin
                state_next = eipg_pkg::EIPG_ST_IDLE;
                tmr_next   = '0;
            end
        endcase
    end

    // Sequencer registers; output follows the low phase exactly
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg    <= eipg_pkg::EIPG_ST_IDLE;
            tmr_reg      <= '0;
            pending_reg  <= 1'b0;
            intn_out_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            tmr_reg      <= tmr_next;
            pending_reg  <= pending_next;
            intn_out_reg <= (state_next != eipg_pkg::EIPG_ST_LOW);
        end
    end

    // Push-pull drive, released to input during init
    assign intn_out = intn_out_reg;
    assign intn_oe  = (mode != eipg_pkg::EIPG_MODE_INIT);

    // ************************************************************
    // Checks
    // ************************************************************
    localparam int HR_MAX = (1 << TW) - 1;

    logic [TW-1:0] low_run_reg;
    logic [TW-1:0] high_run_reg;

    // Run lengths of the output levels, high run saturates
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            low_run_reg  <= '0;
            high_run_reg <= TW'(HR_MAX);
        end else begin
            low_run_reg  <= intn_out_reg ? '0 : low_run_reg + TW'(1);
            high_run_reg <= !intn_out_reg ? '0 :
                            ((high_run_reg == TW'(HR_MAX)) ? high_run_reg : high_run_reg + TW'(1));
        end
    end

    sequence s_pulse_fall;
        $fell(intn_out_reg);
    endsequence

    sequence s_stop_enter_idle;
        stop_entry && (state_reg == eipg_pkg::EIPG_ST_IDLE);
    endsequence

    AST_PULSE_WIDTH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(intn_out_reg) && !$past(sys_rst) && $past(allowed) && $past(allowed, 2) |->
        low_run_reg == TW'(PULSE_CYC))
        else $error("interrupt pulse width wrong");

    AST_MIN_GAP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_pulse_fall |-> $past(high_run_reg) >= TW'(GAP_CYC))
        else $error("interrupt gap too short");

    AST_QUIET_MODES: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !allowed && !$past(allowed) |-> intn_out_reg)
        else $error("interrupt low in quiet mode");

    AST_STOP_ENTRY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_stop_enter_idle |=> !intn_out_reg)
        else $error("no pulse on stop entry");

    AST_SNAPSHOT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_pulse_fall |-> device_status_reg == $past(lat_a[eipg_pkg::IDX_DEV]))
        else $error("status not refreshed at pulse fall");

    AST_SINGLE_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_reg == eipg_pkg::EIPG_ST_LOW) && set_req |=> !pending_reg)
        else $error("event during pulse queued another");

    AST_CYC_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !periodic_irq_enable |-> !rep_due ##1 rep_cnt_reg == '0)
        else $error("periodic repeat while disabled");

    AST_POR_SILENT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_reg == eipg_pkg::EIPG_ST_IDLE) && !pending_reg && !set_req && allowed &&
        ((supply_evt & ~eipg_pkg::SUP_EXCL_MASK) == eipg_pkg::NO_BITS) &&
        (thermal_evt == eipg_pkg::NO_BITS) && (bus_evt == eipg_pkg::NO_BITS) &&
        (high_side_evt == eipg_pkg::NO_BITS) && (drain_source_overvoltage_reg_evt == eipg_pkg::NO_BITS) &&
        (device_evt == eipg_pkg::NO_BITS) && (wake_evt == eipg_pkg::NO_BITS) &&
        (mode == $past(mode)) |=> !trig)
        else $error("excluded supply bit raised a request");

    AST_MASKED_GROUP: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (irq_mask == '0) && !wake_req && !brake_req && !stop_entry && !rep_due |-> !trig)
        else $error("masked group triggered");

    AST_MODE_REPEAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rep_due |=> $fell(intn_out_reg))
        else $error("repeat due without pulse");

endmodule
`default_nettype wire

//--- tb/eipg_host_model.sv
// Host stand-in: clears every status register some time after each pulse.
// Assumes the active-low pulse output and the shared core clock.
`timescale 1ns/1ns
`default_nettype none
module eipg_host_model (
    // Clock and pin
    input  wire logic       ref_clk,
    input  wire logic       intn_out,
    input  wire logic       serve,
    // Clear strobes, one per status register
    output logic      [6:0] clr_v
);
    logic last_q = 1'b1;
    int   wait_q = 0;
    // Delay stands for the serial read latency of a real host
    always @(posedge ref_clk) begin
        clr_v  <= 7'h00;
        last_q <= intn_out;
        if (last_q && !intn_out && serve) wait_q <= 20;
        else if (wait_q > 1) wait_q <= wait_q - 1;
        else if (wait_q == 1) begin
            wait_q <= 0;
            clr_v  <= 7'h7F;
        end
    end
endmodule
`default_nettype wire

//--- tb/event_interrupt_pulse_generator_bench.sv
// Self-checking bench for the interrupt pulse generator.
// Assumes short timer parameters 8, 8 and 64 cycles.
`timescale 1ns/1ns
`default_nettype none
module event_interrupt_pulse_generator_bench;
    logic ref_clk = 1'b0, sys_rst = 1'b1, brake = 1'b0, per_en = 1'b0, intn_in = 1'b1, serve = 1'b1;
    eipg_pkg::eipg_mode_t mode = eipg_pkg::EIPG_MODE_NORMAL;
    logic [7:0] ev [7] = '{default: 8'h00};
    logic [7:0] st [7];
    logic [7:0] v;
    logic [5:0] irq_mask = 6'h3F;
    logic [7:0] wsrc     = 8'hFF;
    logic [6:0] clr_v;
    logic       intn_out, intn_oe, sdm_select, prev = 1'b1;
    int cyc = 0, falls = 0, gap = 0, last_fall = 0, lows = 0, low_len = 0, f0 = 0;
    int mismatches = 0, checked = 0, seed = 32'h6E1C;
    always #2 ref_clk = ~ref_clk;
    eipg_top #(.PULSE_CYC(8), .GAP_CYC(8), .REPEAT_CYC(64)) eipg_top_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mode(mode),
        .supply_evt(ev[0]), .thermal_evt(ev[1]), .bus_evt(ev[2]), .high_side_evt(ev[3]),
        .drain_source_overvoltage_reg_evt(ev[4]), .device_evt(ev[5]), .wake_evt(ev[6]),
        .supply_clr(clr_v[0]), .thermal_clr(clr_v[1]), .bus_clr(clr_v[2]), .high_side_clr(clr_v[3]),
        .drain_source_overvoltage_reg_clr(clr_v[4]), .device_clr(clr_v[5]), .wake_clr(clr_v[6]),
        .irq_mask(irq_mask), .wake_src_en(wsrc), .brake_enable(brake), .periodic_irq_enable(per_en),
        .supply_status_reg(st[0]), .thermal_status_reg(st[1]), .bus_status_reg(st[2]),
        .high_side_fault_reg(st[3]), .drain_source_overvoltage_reg(st[4]), .device_status_reg(st[5]),
        .wake_event_reg(st[6]), .intn_in(intn_in), .intn_out(intn_out), .intn_oe(intn_oe),
        .sdm_select(sdm_select));
    eipg_host_model eipg_host_model_inst (.ref_clk(ref_clk), .intn_out(intn_out), .serve(serve), .clr_v(clr_v));
    // ************************************************************
    // Pulse monitor, timeout and helpers
    // ************************************************************
    always @(posedge ref_clk) begin
        cyc  <= cyc + 1;
        prev <= intn_out;
        lows <= intn_out ? 0 : lows + 1;
        if (prev && !intn_out) begin
            falls     <= falls + 1;
            gap       <= cyc - last_fall;
            last_fall <= cyc;
        end
        if (!prev && intn_out) low_len <= lows;
        if (cyc > 3000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Sequence: each block ends with a progress line
    initial begin
        tick(10);
        sys_rst <= 1'b0;
        tick(2);
        v = 8'($random(seed)) | 8'h01;
        ev[2] <= v;
        ev[3] <= 8'h04;
        tick(1);
        ev[2] <= 8'h00;
        ev[3] <= 8'h00;
        f0 = falls;
        tick(2);
        ev[4] <= 8'h01;
        #1;
        chk("intn low", 32'h0, intn_out);
        chk("bus snapshot", v, st[2]);
        tick(1);
        ev[4] <= 8'h00;
        tick(39);
        chk("pulse width", 32'h8, low_len);
        chk("one pulse", f0 + 1, falls);
        chk("reread cleared", 32'h0, st[2]);
        $display("test joint events done");
        irq_mask <= 6'h3D;
        ev[0] <= 8'h0F;
        ev[1] <= 8'h01;
        f0 = falls;
        tick(1);
        ev[0] <= 8'h00;
        ev[1] <= 8'h00;
        tick(40);
        chk("excluded or masked", f0, falls);
        ev[2] <= 8'h01;
        tick(1);
        ev[2] <= 8'h00;
        tick(3);
        chk("masked latch", 32'h1, st[1]);
        chk("supply latch", 32'hF, st[0]);
        tick(6);
        ev[3] <= 8'h01;
        tick(1);
        ev[3] <= 8'h00;
        tick(40);
        chk("gap kept", 32'h1, gap >= 17);
        chk("held request", f0 + 2, falls);
        $display("test masking and gap done");
        ev[2] <= 8'h01;
        serve <= 1'b0;
        tick(1);
        ev[2] <= 8'h00;
        tick(2);
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        chk("reset releases pin", 32'h1, intn_out);
        chk("reset status", 32'h0, st[2]);
        per_en <= 1'b1;
        irq_mask <= 6'h3F;
        ev[5] <= 8'h02;
        tick(1);
        ev[5] <= 8'h00;
        f0 = falls;
        tick(200);
        chk("repeat spacing", 32'd64, gap);
        chk("repeats", 32'h1, falls - f0 >= 3);
        per_en <= 1'b0;
        tick(70);
        f0 = falls;
        tick(200);
        chk("periodic off", f0, falls);
        $display("test periodic done");
        wsrc <= 8'hFE;
        irq_mask <= 6'h00;
        brake <= 1'b1;
        ev[6] <= 8'h01;
        f0 = falls;
        tick(1);
        ev[6] <= 8'h00;
        tick(20);
        chk("wake not source", f0, falls);
        ev[4] <= 8'h08;
        tick(1);
        ev[4] <= 8'h00;
        tick(20);
        chk("brake wake", f0 + 1, falls);
        $display("test wake sources done");
        f0 = falls;
        irq_mask <= 6'h3F;
        mode <= eipg_pkg::EIPG_MODE_SLEEP;
        tick(2);
        ev[2] <= 8'h02;
        ev[6] <= 8'h02;
        tick(1);
        ev[2] <= 8'h00;
        ev[6] <= 8'h00;
        tick(2);
        mode <= eipg_pkg::EIPG_MODE_RESTART;
        ev[1] <= 8'h01;
        tick(1);
        ev[1] <= 8'h00;
        mode <= eipg_pkg::EIPG_MODE_FAILSAFE;
        ev[3] <= 8'h01;
        tick(1);
        ev[3] <= 8'h00;
        tick(40);
        chk("quiet modes", f0, falls);
        mode <= eipg_pkg::EIPG_MODE_STOP;
        tick(4);
        chk("stop entry", f0 + 1, falls);
        mode <= eipg_pkg::EIPG_MODE_INIT;
        intn_in <= 1'($random(seed));
        tick(3);
        chk("init oe", 32'h0, intn_oe);
        chk("dev select", intn_in, sdm_select);
        $display("test modes done");
        conclude();
    end
endmodule
`default_nettype wire
